// ===== scr_map.vh
// Register offsets, field layouts, reset values and timing constants
`ifndef SCR_MAP_VH
`define SCR_MAP_VH

// =====================================================================
// Register offsets (register indices on the internal register port)
// =====================================================================
`define SCR_ADDR_PRES_GAIN      8'h00
`define SCR_ADDR_CURRENT        8'h01
`define SCR_ADDR_RAW_PRES       8'h02
`define SCR_ADDR_RAW_TEMP       8'h03
`define SCR_ADDR_RATE           8'h04
`define SCR_ADDR_FLAG_MASK      8'h05
`define SCR_ADDR_EXCITATION     8'h06
`define SCR_ADDR_TEMP_GAIN      8'h07
`define SCR_ADDR_CORR_PRES      8'h08

// =====================================================================
// Reset values
// =====================================================================
`define SCR_RST_PRES_GAIN       8'h00
`define SCR_RST_CURRENT         3'h0
`define SCR_RST_RATE            4'h0
`define SCR_RST_FLAG_MASK       10'h0ff
`define SCR_RST_EXCITATION      3'h0
`define SCR_RST_TEMP_GAIN       8'h00
`define SCR_RST_RESULT          16'h0000

// =====================================================================
// Field layouts and codes
// =====================================================================
`define SCR_PGAIN_RANGE         5:4
`define SCR_PGAIN_STEP          3:0
`define SCR_PGAIN_HI_STEP       3:2
`define SCR_PGAIN_RANGE_LOW     2'h0
`define SCR_PGAIN_RANGE_HIGH    2'h1
`define SCR_TGAIN_STEP          3:0
`define SCR_RATE_PRES           3:1
`define SCR_RATE_TEMP           0
`define SCR_RATE_MAX            4'h9
`define SCR_EXC_OFF             3'h0
`define SCR_EXC_CURRENT         3'h1
`define SCR_EXC_MAX             3'h5
`define SCR_FLAG_EXCITATION_PIN_FAULT      11
`define SCR_FLAG_THERM_FAULT    10
`define SCR_FLAG_MASKED         9:0

// =====================================================================
// Timing
// =====================================================================
`define SCR_CLK_PERIOD_PS       5000
`define SCR_SWITCH_1K_PS        500000000
`define SCR_TEMP_RATIO_1SPS     10'h3e8
`define SCR_TEMP_RATIO_10SPS    10'h064

`endif

// ===== scr_conv_seq.v
// Conversion sequencer: pressure starts at the chosen rate, temperature slotted between
`timescale 1ns/10ps
`default_nettype none
`include "scr_map.vh"

module scr_conv_seq #(
    parameter integer SWITCH_CYCLES = `SCR_SWITCH_1K_PS / `SCR_CLK_PERIOD_PS
) (
    input  wire       clock_in,
    input  wire       reset_in,
    input  wire [2:0] pres_rate_in,
    input  wire       temp_fast_in,
    output reg        pres_start_out,
    output reg        temp_start_out
);

    localparam [17:0] SWITCH_BASE = SWITCH_CYCLES[17:0];

    reg  [17:0] phase_reg;
    reg  [13:0] pres_count_reg;
    reg         temp_due_reg;
    wire [17:0] switch_len;
    wire [17:0] period_len;
    wire [13:0] temp_ratio;

    // Switch time halves with each rate step; the pressure period is twice it
    assign switch_len = SWITCH_BASE >> pres_rate_in;
    assign period_len = {switch_len[16:0], 1'b0};
    // Temperature rate is fixed in sps, so pressure starts per slot double each step
    assign temp_ratio = temp_fast_in ? ({4'h0, `SCR_TEMP_RATIO_10SPS} << pres_rate_in)
                                     : ({4'h0, `SCR_TEMP_RATIO_1SPS} << pres_rate_in);

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            phase_reg      <= 18'h0_0000;
            pres_count_reg <= 14'h0000;
            temp_due_reg   <= 1'b0;
            pres_start_out <= 1'b0;
            temp_start_out <= 1'b0;
        end else begin
            pres_start_out <= 1'b0;
            temp_start_out <= 1'b0;
            // Pressure cadence never waits for temperature
            if (phase_reg >= period_len - 18'h0_0001) begin
                phase_reg      <= 18'h0_0000;
                pres_start_out <= 1'b1;
                if (pres_count_reg >= temp_ratio - 14'h0001) begin
                    pres_count_reg <= 14'h0000;
                    temp_due_reg   <= 1'b1;
                end else begin
                    pres_count_reg <= pres_count_reg + 14'h0001;
                end
            end else begin
                phase_reg <= phase_reg + 18'h0_0001;
            end
            // Temperature slot one switch time after the pressure start
            if (temp_due_reg && phase_reg == switch_len - 18'h0_0001) begin
                temp_start_out <= 1'b1;
                temp_due_reg   <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ===== scr_regs.v
// Sensor front-end configuration and measurement register bank
`timescale 1ns/10ps
`default_nettype none
`include "scr_map.vh"

// How it works
// - Three-bit bridge current code selects 250 to 750 microamps.
// - Raw pressure holds latest uncalibrated pressure conversion, read only.
// - Pressure values are 16-bit two's complement, zero at mid-scale.
// - Pressure LSB is 1/32768 of full scale, passed unchanged.
// - Raw temperature holds latest uncalibrated signed temperature conversion, read only.
// - Rate bits 3:1 pick pressure 1 to 16 ksps; bit 0 picks 1 or 10 sps temperature.
// - Pressure to temperature switch time is half the pressure period.
// - Temperature conversions slot between pressure ones without delaying them.
// - Each mask bit enables the status flag at the same position.
// - Mask resets to 0x0ff.
// - Bridge drive codes: off, current, 4V, 3.3V, 1.8V, 2.3V; off after reset.
// - Current drive uses internal ADC reference; voltage drive uses bridge voltage.
// - Temperature gain bits 3:0 pick 1.5 to 90 V/V.
// - Temperature gain bits 7:4 are spare and never decoded.
// - Corrected pressure holds latest calibrated pressure, same format.
// - Drive and thermistor pin faults always reach the alert, unmasked.
// - Pressure gain bits 7:6 are reserved and never decoded.
module scr_regs #(
    parameter integer SWITCH_CYCLES = `SCR_SWITCH_1K_PS / `SCR_CLK_PERIOD_PS
) (
    input  wire        clock_in,
    input  wire        reset_in,
    // Register port from the serial management interface
    input  wire [7:0]  reg_addr_in,
    input  wire        reg_wr_in,
    input  wire [15:0] reg_wdata_in,
    input  wire        reg_rd_in,
    output reg  [15:0] reg_rdata_out,
    output reg         reg_rvalid_out,
    // Conversion results from the ADC and calibration engine
    input  wire        adc_done_in,
    input  wire        adc_is_temp_in,
    input  wire [15:0] adc_data_in,
    input  wire        cal_pres_done_in,
    input  wire [15:0] cal_pres_data_in,
    // Status flags from the status block
    input  wire [11:0] status_flags_in,
    // Analog settings, conversion starts, ready strobes and alert
    output reg  [11:0] pres_gain_vv_out,
    output reg  [9:0]  temp_gain_tenths_out,
    output reg  [9:0]  bridge_current_ua_out,
    output reg  [2:0]  excitation_mode_out,
    output reg         adc_ref_bridge_out,
    output reg  [2:0]  pres_rate_out,
    output reg         temp_fast_out,
    output wire        pres_start_out,
    output wire        temp_start_out,
    output reg         pres_ready_out,
    output reg         temp_ready_out,
    output reg         alert_n_out
);

    // =================================================================
    // Decode functions
    // =================================================================
    function [11:0] pres_gain_decode;
        input [7:0] code;
        begin
            pres_gain_decode = 12'h00a;
            if (code[`SCR_PGAIN_RANGE] == `SCR_PGAIN_RANGE_LOW) begin
                case (code[`SCR_PGAIN_STEP])
                    4'h0:    pres_gain_decode = 12'h00a;
                    4'h1:    pres_gain_decode = 12'h00f;
                    4'h2:    pres_gain_decode = 12'h014;
                    4'h3:    pres_gain_decode = 12'h018;
                    4'h4:    pres_gain_decode = 12'h028;
                    4'h5:    pres_gain_decode = 12'h03c;
                    4'h6:    pres_gain_decode = 12'h048;
                    4'h7:    pres_gain_decode = 12'h05a;
                    4'h8:    pres_gain_decode = 12'h06c;
                    4'h9:    pres_gain_decode = 12'h07e;
                    4'ha:    pres_gain_decode = 12'h090;
                    4'hb:    pres_gain_decode = 12'h0a0;
                    4'hc:    pres_gain_decode = 12'h0b4;
                    4'hd:    pres_gain_decode = 12'h0c8;
                    4'he:    pres_gain_decode = 12'h0fc;
                    default: pres_gain_decode = 12'h005;
                endcase
            end else begin
                case (code[1:0])
                    2'h0:    pres_gain_decode = 12'h21c;
                    2'h1:    pres_gain_decode = 12'h438;
                    2'h2:    pres_gain_decode = 12'h5a0;
                    default: pres_gain_decode = 12'h9d8;
                endcase
            end
        end
    endfunction

    function pres_gain_valid;
        input [7:0] code;
        begin
            pres_gain_valid = (code[`SCR_PGAIN_RANGE] == `SCR_PGAIN_RANGE_LOW) ||
                              (code[`SCR_PGAIN_RANGE] == `SCR_PGAIN_RANGE_HIGH &&
                               code[`SCR_PGAIN_HI_STEP] == 2'h0);
        end
    endfunction

    function [9:0] temp_gain_decode;
        input [3:0] step;
        begin
            case (step)
                4'h0:    temp_gain_decode = 10'h00f;
                4'h1:    temp_gain_decode = 10'h014;
                4'h2:    temp_gain_decode = 10'h01e;
                4'h3:    temp_gain_decode = 10'h032;
                4'h4:    temp_gain_decode = 10'h03c;
                4'h5:    temp_gain_decode = 10'h064;
                4'h6:    temp_gain_decode = 10'h096;
                4'h7:    temp_gain_decode = 10'h0c8;
                4'h8:    temp_gain_decode = 10'h0f0;
                4'h9:    temp_gain_decode = 10'h12c;
                4'ha:    temp_gain_decode = 10'h168;
                4'hb:    temp_gain_decode = 10'h190;
                4'hc:    temp_gain_decode = 10'h1c2;
                4'hd:    temp_gain_decode = 10'h258;
                4'he:    temp_gain_decode = 10'h2d0;
                default: temp_gain_decode = 10'h384;
            endcase
        end
    endfunction

    function [9:0] current_decode;
        input [2:0] code;
        begin
            case (code)
                3'h0:    current_decode = 10'h0fa;
                3'h1:    current_decode = 10'h12c;
                3'h2:    current_decode = 10'h190;
                3'h3:    current_decode = 10'h1c2;
                3'h4:    current_decode = 10'h1f4;
                3'h5:    current_decode = 10'h226;
                3'h6:    current_decode = 10'h28a;
                default: current_decode = 10'h2ee;
            endcase
        end
    endfunction

    // =================================================================
    // Register storage
    // =================================================================
    reg  [7:0]  pressure_amp_gain_reg;
    reg  [2:0]  bridge_current_select_reg;
    reg  [15:0] raw_pressure_result_reg;
    reg  [15:0] raw_temperature_result_reg;
    reg  [3:0]  conversion_rate_select_reg;
    reg  [9:0]  flag_mask_reg;
    reg  [2:0]  bridge_excitation_select_reg;
    reg  [7:0]  temperature_amp_gain_reg;
    reg  [15:0] corrected_pressure_result_reg;
    reg  [15:0] rdata_next;
    wire        wr_pgain;
    wire        wr_rate;
    wire        wr_exc;

    assign wr_pgain = reg_wr_in && reg_addr_in == `SCR_ADDR_PRES_GAIN;
    assign wr_rate  = reg_wr_in && reg_addr_in == `SCR_ADDR_RATE;
    assign wr_exc   = reg_wr_in && reg_addr_in == `SCR_ADDR_EXCITATION;

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            pressure_amp_gain_reg        <= `SCR_RST_PRES_GAIN;
            bridge_current_select_reg    <= `SCR_RST_CURRENT;
            conversion_rate_select_reg   <= `SCR_RST_RATE;
            flag_mask_reg                <= `SCR_RST_FLAG_MASK;
            bridge_excitation_select_reg <= `SCR_RST_EXCITATION;
            temperature_amp_gain_reg     <= `SCR_RST_TEMP_GAIN;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `SCR_ADDR_PRES_GAIN:  pressure_amp_gain_reg        <= reg_wdata_in[7:0];
                `SCR_ADDR_CURRENT:    bridge_current_select_reg    <= reg_wdata_in[2:0];
                `SCR_ADDR_RATE:       conversion_rate_select_reg   <= reg_wdata_in[3:0];
                `SCR_ADDR_FLAG_MASK:  flag_mask_reg                <= reg_wdata_in[9:0];
                `SCR_ADDR_EXCITATION: bridge_excitation_select_reg <= reg_wdata_in[2:0];
                `SCR_ADDR_TEMP_GAIN:  temperature_amp_gain_reg     <= reg_wdata_in[7:0];
                // Result registers take no write
                default: begin
                end
            endcase
        end
    end

    // =================================================================
    // Measurement capture
    // =================================================================
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            raw_pressure_result_reg       <= `SCR_RST_RESULT;
            raw_temperature_result_reg    <= `SCR_RST_RESULT;
            corrected_pressure_result_reg <= `SCR_RST_RESULT;
            pres_ready_out                <= 1'b0;
            temp_ready_out                <= 1'b0;
        end else begin
            pres_ready_out <= adc_done_in && !adc_is_temp_in;
            temp_ready_out <= adc_done_in && adc_is_temp_in;
            // Whole-word capture, two's complement kept bit for bit
            if (adc_done_in && !adc_is_temp_in) begin
                raw_pressure_result_reg <= adc_data_in;
            end
            if (adc_done_in && adc_is_temp_in) begin
                raw_temperature_result_reg <= adc_data_in;
            end
            if (cal_pres_done_in) begin
                corrected_pressure_result_reg <= cal_pres_data_in;
            end
        end
    end

    // =================================================================
    // Applied analog selections
    // =================================================================
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            pres_gain_vv_out      <= 12'h00a;
            temp_gain_tenths_out  <= 10'h00f;
            bridge_current_ua_out <= 10'h0fa;
            excitation_mode_out   <= `SCR_EXC_OFF;
            adc_ref_bridge_out    <= 1'b0;
            pres_rate_out         <= 3'h0;
            temp_fast_out         <= 1'b0;
        end else begin
            // Bits 7:6 never reach the decoder; reserved codes keep the old gain
            if (wr_pgain && pres_gain_valid(reg_wdata_in[7:0])) begin
                pres_gain_vv_out <= pres_gain_decode({2'h0, reg_wdata_in[5:0]});
            end
            temp_gain_tenths_out  <= temp_gain_decode(temperature_amp_gain_reg[`SCR_TGAIN_STEP]);
            bridge_current_ua_out <= current_decode(bridge_current_select_reg);
            if (wr_exc && reg_wdata_in[2:0] <= `SCR_EXC_MAX) begin
                excitation_mode_out <= reg_wdata_in[2:0];
                // Bridge reference for any voltage drive, internal otherwise
                adc_ref_bridge_out  <= reg_wdata_in[2:0] > `SCR_EXC_CURRENT;
            end
            if (wr_rate && reg_wdata_in[3:0] <= `SCR_RATE_MAX) begin
                pres_rate_out <= reg_wdata_in[`SCR_RATE_PRES];
                temp_fast_out <= reg_wdata_in[`SCR_RATE_TEMP];
            end
        end
    end

    // =================================================================
    // Conversion sequencer
    // =================================================================
    scr_conv_seq #(
        .SWITCH_CYCLES (SWITCH_CYCLES)
    ) u_seq (
        .clock_in       (clock_in),
        .reset_in       (reset_in),
        .pres_rate_in   (pres_rate_out),
        .temp_fast_in   (temp_fast_out),
        .pres_start_out (pres_start_out),
        .temp_start_out (temp_start_out)
    );

    // =================================================================
    // Alert
    // =================================================================
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            alert_n_out <= 1'b1;
        end else begin
            alert_n_out <= !((|(status_flags_in[`SCR_FLAG_MASKED] & flag_mask_reg)) ||
                             status_flags_in[`SCR_FLAG_EXCITATION_PIN_FAULT] ||
                             status_flags_in[`SCR_FLAG_THERM_FAULT]);
        end
    end

    // =================================================================
    // Read path
    // =================================================================
    always @* begin
        rdata_next = 16'h0000;
        case (reg_addr_in)
            `SCR_ADDR_PRES_GAIN:  rdata_next = {8'h00, pressure_amp_gain_reg};
            `SCR_ADDR_CURRENT:    rdata_next = {13'h0000, bridge_current_select_reg};
            `SCR_ADDR_RAW_PRES:   rdata_next = raw_pressure_result_reg;
            `SCR_ADDR_RAW_TEMP:   rdata_next = raw_temperature_result_reg;
            `SCR_ADDR_RATE:       rdata_next = {12'h000, conversion_rate_select_reg};
            `SCR_ADDR_FLAG_MASK:  rdata_next = {6'h00, flag_mask_reg};
            `SCR_ADDR_EXCITATION: rdata_next = {13'h0000, bridge_excitation_select_reg};
            `SCR_ADDR_TEMP_GAIN:  rdata_next = {8'h00, temperature_amp_gain_reg};
            `SCR_ADDR_CORR_PRES:  rdata_next = corrected_pressure_result_reg;
            default:              rdata_next = 16'h0000;
        endcase
    end

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out  <= 16'h0000;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= rdata_next;
            end
        end
    end

endmodule
`default_nettype wire

// ===== scr_regs_monitor.sv
// Port-level assertions for the register bank
`timescale 1ns/10ps
`default_nettype none
module scr_regs_mon (
    input wire logic        clock_in,
    input wire logic        reset_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic        reg_wr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        reg_rd_in,
    input wire logic        reg_rvalid_out,
    input wire logic        adc_done_in,
    input wire logic        adc_is_temp_in,
    input wire logic [11:0] status_flags_in,
    input wire logic [2:0]  excitation_mode_out,
    input wire logic        adc_ref_bridge_out,
    input wire logic [2:0]  pres_rate_out,
    input wire logic        temp_fast_out,
    input wire logic        pres_start_out,
    input wire logic        temp_start_out,
    input wire logic        pres_ready_out,
    input wire logic        temp_ready_out,
    input wire logic        alert_n_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered");
    a_rvalid_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
        else $error("read valid without read");
    a_alert_fault: assert property (|status_flags_in[11:10] |=> !alert_n_out)
        else $error("pin fault not on alert");
    a_alert_quiet: assert property (status_flags_in == 12'h000 |=> alert_n_out)
        else $error("alert without flag");
    a_ref_current: assert property (excitation_mode_out == 3'h1 |-> !adc_ref_bridge_out)
        else $error("current drive not on internal reference");
    a_ref_voltage: assert property (excitation_mode_out >= 3'h2 |-> adc_ref_bridge_out)
        else $error("voltage drive not on bridge reference");
    a_drive_hold: assert property (reg_wr_in && reg_addr_in == 8'h06 && reg_wdata_in[2:0] > 3'h5
        |=> $stable(excitation_mode_out))
        else $error("reserved drive code applied");
    a_rate_hold: assert property (reg_wr_in && reg_addr_in == 8'h04 && reg_wdata_in[3:0] > 4'h9
        |=> $stable(pres_rate_out) && $stable(temp_fast_out))
        else $error("reserved rate code applied");
    a_ready_kind: assert property (adc_done_in && !adc_is_temp_in |=> pres_ready_out && !temp_ready_out)
        else $error("pressure ready missing");
    a_start_apart: assert property (pres_start_out |-> !temp_start_out)
        else $error("temperature start collides with pressure");
endmodule
bind scr_regs scr_regs_mon scr_regs_mon_i (.clock_in, .reset_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in,
    .reg_rd_in, .reg_rvalid_out, .adc_done_in, .adc_is_temp_in, .status_flags_in, .excitation_mode_out,
    .adc_ref_bridge_out, .pres_rate_out, .temp_fast_out, .pres_start_out, .temp_start_out,
    .pres_ready_out, .temp_ready_out, .alert_n_out);
`default_nettype wire

// ===== scr_host_model.sv
// Host model driving the register port
`timescale 1ns/10ps
`default_nettype none
module scr_host_model (
    input  wire logic        clock_in,
    input  wire logic [15:0] rdata_in,
    input  wire logic        rvalid_in,
    output var  logic [7:0]  addr_out,
    output var  logic        wr_out,
    output var  logic [15:0] wdata_out,
    output var  logic        rd_out
);
    initial begin
        addr_out = 8'h00;
        wr_out = 1'b0;
        wdata_out = 16'h0000;
        rd_out = 1'b0;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(negedge clock_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(negedge clock_in);
        wr_out <= 1'b0;
        wdata_out <= ~d;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d, output logic v);
        @(negedge clock_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(negedge clock_in);
        rd_out <= 1'b0;
        d = rdata_in;
        v = rvalid_in;
    endtask
endmodule
`default_nettype wire

// ===== scr_regs_tb.sv
// Self-checking bench for the register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; \
    $display("ERROR %s expected %0h seen %0h", n, e, a); end end
module scr_regs_tb;
    localparam int SW = 16;
    logic        clock_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [7:0]  addr;
    logic        wr_s, rd, rvalid, v, ref_o, fast_o, ps, ts, prdy, trdy, alert_n;
    logic [15:0] wdata, rdata, d;
    logic        done = 1'b0, is_temp = 1'b0, cal_done = 1'b0;
    logic [15:0] adata = 16'h0000, cdata = 16'h0000;
    logic [11:0] flags = 12'h000, pg_o;
    logic [9:0]  tg_o, cu_o;
    logic [2:0]  mode_o, rate_o;
    int          fails = 0, checked = 0;
    int          pg[20] = '{10, 15, 20, 24, 40, 60, 72, 90, 108, 126, 144, 160, 180, 200, 252, 5, 540, 1080, 1440, 2520};
    int          tg[16] = '{15, 20, 30, 50, 60, 100, 150, 200, 240, 300, 360, 400, 450, 600, 720, 900};
    int          cu[8] = '{250, 300, 400, 450, 500, 550, 650, 750};
    logic [22:0] al[7] = '{{10'h0ff, 12'h100, 1'b1}, {10'h0ff, 12'h001, 1'b0}, {10'h3fe, 12'h001, 1'b1},
        {10'h3fe, 12'h200, 1'b0}, {10'h000, 12'h800, 1'b0}, {10'h000, 12'h400, 1'b0}, {10'h000, 12'h0ff, 1'b1}};
    always #2.5 clock_in = ~clock_in;
    scr_regs #(.SWITCH_CYCLES(SW)) scr_regs_i (.clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(addr),
        .reg_wr_in(wr_s), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .adc_done_in(done), .adc_is_temp_in(is_temp), .adc_data_in(adata), .cal_pres_done_in(cal_done),
        .cal_pres_data_in(cdata), .status_flags_in(flags), .pres_gain_vv_out(pg_o), .temp_gain_tenths_out(tg_o),
        .bridge_current_ua_out(cu_o), .excitation_mode_out(mode_o), .adc_ref_bridge_out(ref_o),
        .pres_rate_out(rate_o), .temp_fast_out(fast_o), .pres_start_out(ps), .temp_start_out(ts),
        .pres_ready_out(prdy), .temp_ready_out(trdy), .alert_n_out(alert_n));
    scr_host_model scr_host_model_i (.clock_in(clock_in), .rdata_in(rdata), .rvalid_in(rvalid), .addr_out(addr),
        .wr_out(wr_s), .wdata_out(wdata), .rd_out(rd));
    task automatic end_sim;
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] x);
        scr_host_model_i.wr_reg(a, x);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        scr_host_model_i.rd_reg(a, d, v);
        `CHK("rvalid", 1'b1, v)
        `CHK("rdata", e, d)
    endtask
    task automatic conv(input logic t, input logic [15:0] x);
        @(negedge clock_in);
        done = 1'b1;
        is_temp = t;
        adata = x;
        @(negedge clock_in);
        done = 1'b0;
        adata = ~x;
        `CHK("ready", 1'b1, t ? trdy : prdy)
    endtask
    // Pressure period, temperature slot and temperature cadence for one rate code
    task automatic meas(input logic [3:0] code);
        int since, np;
        since = -1;
        np = -1;
        wr(8'h04, {12'h000, code});
        for (int i = 0; i < 9000; i++) begin
            @(negedge clock_in);
            if (since >= 0)
                since++;
            if (ts && since >= 0) begin
                if (np >= 0) begin
                    `CHK("t_count", (code[0] ? 100 : 1000) << code[3:1], np)
                    return;
                end
                `CHK("t_slot", SW >> code[3:1], since)
                np = 0;
            end
            if (ps) begin
                if (since > 0)
                    `CHK("p_period", (2 * SW) >> code[3:1], since)
                since = 0;
                if (np >= 0)
                    np++;
            end
        end
        fails++;
        end_sim();
    endtask
    initial begin
        repeat (16) @(negedge clock_in);
        reset_in = 1'b0;
        rchk(8'h05, 16'h00ff);
        `CHK("mode", 3'h0, mode_o)
        for (int i = 0; i < 20; i++) begin
            wr(8'h00, 16'(i) | 16'h00c0);
            rchk(8'h00, 16'(i) | 16'h00c0);
            `CHK("pgain", 12'(pg[i]), pg_o)
        end
        for (int i = 0; i < 16; i++) begin
            wr(8'h07, 16'(i) | 16'h00a0);
            rchk(8'h07, 16'(i) | 16'h00a0);
            `CHK("tgain", 10'(tg[i]), tg_o)
        end
        for (int i = 0; i < 8; i++) begin
            wr(8'h01, 16'(i));
            rchk(8'h01, 16'(i));
            `CHK("current", 10'(cu[i]), cu_o)
        end
        for (int i = 0; i < 6; i++) begin
            wr(8'h06, 16'(i));
            rchk(8'h06, 16'(i));
            `CHK("mode", 3'(i), mode_o)
            if (i > 0)
                `CHK("ref", i > 1, ref_o)
        end
        for (int i = 0; i < 10; i++) begin
            wr(8'h04, 16'(i));
            rchk(8'h04, 16'(i));
            `CHK("rate", 3'(i / 2), rate_o)
            `CHK("fast", 1'(i % 2), fast_o)
        end
        wr(8'h06, 16'h0007);
        rchk(8'h06, 16'h0007);
        `CHK("mode_held", 3'h5, mode_o)
        wr(8'h04, 16'h000b);
        `CHK("rate_held", 3'h4, rate_o)
        wr(8'h00, 16'h0025);
        `CHK("pgain_held", 12'd2520, pg_o)
        for (int i = 0; i < 7; i++) begin
            wr(8'h05, {6'h00, al[i][22:13]});
            flags = al[i][12:1];
            repeat (2) @(negedge clock_in);
            `CHK("alert_n", al[i][0], alert_n)
        end
        flags = 12'h000;
        conv(1'b0, 16'h8000);
        conv(1'b1, 16'h7fff);
        @(negedge clock_in);
        cal_done = 1'b1;
        cdata = 16'h0001;
        @(negedge clock_in);
        cal_done = 1'b0;
        cdata = 16'hfffe;
        rchk(8'h02, 16'h8000);
        rchk(8'h03, 16'h7fff);
        rchk(8'h08, 16'h0001);
        wr(8'h02, 16'h1234);
        rchk(8'h02, 16'h8000);
        rchk(8'h0f, 16'h0000);
        conv(1'b0, 16'h7fff);
        rchk(8'h02, 16'h7fff);
        @(negedge clock_in);
        reset_in = 1'b1;
        repeat (3) @(negedge clock_in);
        reset_in = 1'b0;
        rchk(8'h05, 16'h00ff);
        `CHK("mode_rst", 3'h0, mode_o)
        meas(4'h9);
        meas(4'h1);
        end_sim();
    end
endmodule
`default_nettype wire
